// ---- hdl/pps_low_filter.sv ----
module pps_low_filter #(
	parameter int CYCLES = 250
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fault_in,
	output logic fault_out
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
	logic [CW-1:0] cnt_reg;

	// A fault must persist unbroken for the full window; any gap restarts it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			fault_out <= 1'b0;
		end else if (!fault_in) begin
			cnt_reg <= '0;
			fault_out <= 1'b0;
		end else if (cnt_reg != LIMIT) begin
			cnt_reg <= cnt_reg + CW'(1);
		end else begin
			fault_out <= 1'b1;
		end
	end
endmodule : pps_low_filter

// ---- hdl/pps_pkg.sv ----
package pps_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NPORT = 4;
	localparam int SYNC_W = 17;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SPLIT = 8'h04;
	localparam logic [7:0] REG_PWR = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_MASK = 8'h10;
	localparam logic [7:0] REG_STATE = 8'h14;
	localparam logic [7:0] REG_OCLIVE = 8'h18;

	localparam logic [2:0] CTRL_RESET = 3'h2;
	localparam int CTRL_DFP = 0;
	localparam int CTRL_VCONN_AUTO = 1;
	localparam int CTRL_WIN_0V = 2;
	localparam logic [3:0] SPLIT_RESET = 4'h0;
	localparam logic [7:0] PWR_RESET = 8'h00;
	localparam logic [11:0] MASK_RESET = 12'h000;

	localparam int ST_VCONN_OC = 8;
	localparam int ST_ATTACH = 9;
	localparam int ST_DETACH = 10;
	localparam int ST_VBUS_WIN = 11;
	localparam int ST_W = 12;

	localparam int CLK_NS = 4;
	localparam int OC_FILT_NS = 1000;
	localparam int OC_FILT_CYC = (OC_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int VCONN_FILT_NS = 2000;
	localparam int VCONN_FILT_CYC = (VCONN_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] CFG_SETTLE_CYC = 2'h3;

	localparam logic [3:0] SPLIT_OK_CFG1 = 4'hE;
	localparam logic [3:0] SPLIT_OK_CFG2 = 4'h8;

	typedef enum logic [1:0] {
		PPS_VC_IDLE,
		PPS_VC_ON,
		PPS_VC_LOCKED
	} pps_vconn_t;

	function automatic logic [3:0] pps_split_allowed(input logic cfg2);
		pps_split_allowed = cfg2 ? SPLIT_OK_CFG2 : SPLIT_OK_CFG1;
	endfunction : pps_split_allowed
endpackage : pps_pkg

// ---- hdl/pps_port_power.sv ----
// Local design decisions: the address-and-strobe port and the register offsets.
module pps_port_power (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [pps_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [pps_pkg::DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [pps_pkg::DATA_W-1:0] bus_rdata,
	output logic irq,
	input wire logic pin_cfg_strap,
	input wire logic cc1_term_det,
	input wire logic cc2_term_det,
	input wire logic cc1_ra_det,
	input wire logic cc2_ra_det,
	input wire logic cc1_vconn_low,
	input wire logic cc2_vconn_low,
	input wire logic bus_voltage_monitor_in_safe5v,
	input wire logic bus_voltage_monitor_in_safe0v,
	input wire logic [pps_pkg::NPORT-1:0] port_power_sense_pin_in,
	output logic [pps_pkg::NPORT-1:0] port_power_sense_pin_out,
	output logic [pps_pkg::NPORT-1:0] port_power_sense_pin_oe_b,
	output logic [pps_pkg::NPORT-1:0] port_power_sense_pin_pu_en,
	input wire logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_in,
	output logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_out,
	output logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_oe_b,
	output logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_pu_en,
	output logic port1_cable_supply_enable_a,
	output logic port1_cable_supply_enable_b
);
	import pps_pkg::*;

	logic [SYNC_W-1:0] raw_in;
	logic [SYNC_W-1:0] syn;
	logic s_cfg;
	logic s_cc1_term;
	logic s_cc2_term;
	logic s_cc1_ra;
	logic s_cc2_ra;
	logic s_cc1_low;
	logic s_cc2_low;
	logic s_v5;
	logic s_v0;
	logic [NPORT-1:0] s_pp_in;
	logic [NPORT-1:0] s_ss_in;

	logic [1:0] cfg_cnt_reg;
	logic cfg_reg;
	logic [2:0] ctrl_reg;
	logic [3:0] split_reg;
	logic [7:0] pwr_reg;
	logic [ST_W-1:0] stat_reg;
	logic [ST_W-1:0] stat_next;
	logic [ST_W-1:0] stat_set;
	logic [ST_W-1:0] mask_reg;

	logic [NPORT-1:0] split_eff;
	logic [NPORT-1:0] main_on;
	logic [NPORT-1:0] ss_on;
	logic [NPORT-1:0] main_fault;
	logic [NPORT-1:0] ss_fault;
	logic [NPORT-1:0] main_oc;
	logic [NPORT-1:0] ss_oc;
	logic [NPORT-1:0] main_oc_prev_reg;
	logic [NPORT-1:0] ss_oc_prev_reg;

	logic dfp;
	logic attached_reg;
	logic attached_next;
	logic orient_reg;
	logic vbus_win;
	logic vbus_win_prev_reg;
	logic pd_ok_reg;
	logic ra_pin;
	logic low_pin;
	logic vc_fault;
	logic vc_oc;
	pps_vconn_t vc_state_reg;
	pps_vconn_t vc_state_next;

	logic wr_ctrl;
	logic wr_split;
	logic wr_pwr;
	logic wr_stat;
	logic wr_mask;

	assign raw_in = {pin_cfg_strap, cc1_term_det, cc2_term_det, cc1_ra_det, cc2_ra_det,
		cc1_vconn_low, cc2_vconn_low, bus_voltage_monitor_in_safe5v,
		bus_voltage_monitor_in_safe0v, port_power_sense_pin_in, superspeed_power_sense_pin_in};

	pps_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(raw_in),
		.q(syn)
	);

	assign {s_cfg, s_cc1_term, s_cc2_term, s_cc1_ra, s_cc2_ra, s_cc1_low, s_cc2_low,
		s_v5, s_v0, s_pp_in, s_ss_in} = syn;

	// The strap is sampled after the synchroniser has flushed its reset value.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_cnt_reg <= 2'h0;
			cfg_reg <= 1'b0;
		end else if (cfg_cnt_reg != CFG_SETTLE_CYC) begin
			cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
			cfg_reg <= s_cfg;
		end
	end

	assign wr_ctrl = bus_wr && (bus_addr == REG_CTRL);
	assign wr_split = bus_wr && (bus_addr == REG_SPLIT);
	assign wr_pwr = bus_wr && (bus_addr == REG_PWR);
	assign wr_stat = bus_wr && (bus_addr == REG_STAT);
	assign wr_mask = bus_wr && (bus_addr == REG_MASK);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= bus_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			split_reg <= SPLIT_RESET;
		end else if (wr_split) begin
			split_reg <= bus_wdata[3:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_reg <= PWR_RESET;
		end else if (wr_pwr) begin
			pwr_reg <= bus_wdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_reg <= MASK_RESET;
		end else if (wr_mask) begin
			mask_reg <= bus_wdata[ST_W-1:0];
		end
	end

	// Split requests on ports that the pin configuration cannot split are ignored.
	assign split_eff = split_reg & pps_split_allowed(cfg_reg);
	assign main_on = pwr_reg[3:0];
	assign ss_on = split_eff & pwr_reg[7:4];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port_power_sense_pin_out <= '0;
			port_power_sense_pin_oe_b <= '0;
			port_power_sense_pin_pu_en <= '0;
		end else begin
			port_power_sense_pin_out <= '0;
			port_power_sense_pin_oe_b <= main_on;
			port_power_sense_pin_pu_en <= main_on;
		end
	end

	// An unsplit superspeed pin is released with no pull-up so it draws nothing.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			superspeed_power_sense_pin_out <= '0;
			superspeed_power_sense_pin_oe_b <= '1;
			superspeed_power_sense_pin_pu_en <= '0;
		end else begin
			superspeed_power_sense_pin_out <= '0;
			superspeed_power_sense_pin_oe_b <= ~split_eff | ss_on;
			superspeed_power_sense_pin_pu_en <= ss_on;
		end
	end

	// Sensing only counts while the pin is released; a driven low is our own.
	assign main_fault = port_power_sense_pin_pu_en & main_on & ~s_pp_in;
	assign ss_fault = superspeed_power_sense_pin_pu_en & ss_on & ~s_ss_in;

	for (genvar i = 0; i < NPORT; i++) begin : g_oc
		pps_low_filter #(
			.CYCLES(OC_FILT_CYC)
		) u_main_filt (
			.clk(clk),
			.rst_b(rst_b),
			.fault_in(main_fault[i]),
			.fault_out(main_oc[i])
		);
		pps_low_filter #(
			.CYCLES(OC_FILT_CYC)
		) u_ss_filt (
			.clk(clk),
			.rst_b(rst_b),
			.fault_in(ss_fault[i]),
			.fault_out(ss_oc[i])
		);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			main_oc_prev_reg <= '0;
			ss_oc_prev_reg <= '0;
		end else begin
			main_oc_prev_reg <= main_oc;
			ss_oc_prev_reg <= ss_oc;
		end
	end

	assign dfp = ctrl_reg[CTRL_DFP];

	always_comb begin
		if (dfp) begin
			attached_next = s_cc1_term | s_cc2_term;
		end else if (attached_reg) begin
			attached_next = ~s_v0;
		end else begin
			attached_next = s_v5;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			attached_reg <= 1'b0;
		end else begin
			attached_reg <= attached_next;
		end
	end

	// Orientation is frozen at attach so the supply never hops pins mid-session.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			orient_reg <= 1'b0;
		end else if (attached_next && !attached_reg) begin
			orient_reg <= s_cc2_term;
		end
	end

	assign vbus_win = ctrl_reg[CTRL_WIN_0V] ? s_v0 : s_v5;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vbus_win_prev_reg <= 1'b0;
			pd_ok_reg <= 1'b0;
		end else begin
			vbus_win_prev_reg <= vbus_win;
			pd_ok_reg <= dfp && attached_reg && vbus_win;
		end
	end

	// The cable supply goes on the pin that is not carrying signalling.
	assign ra_pin = orient_reg ? s_cc1_ra : s_cc2_ra;
	assign low_pin = orient_reg ? s_cc1_low : s_cc2_low;

	pps_low_filter #(
		.CYCLES(VCONN_FILT_CYC)
	) u_vconn_filt (
		.clk(clk),
		.rst_b(rst_b),
		.fault_in((vc_state_reg == PPS_VC_ON) && low_pin),
		.fault_out(vc_fault)
	);

	always_comb begin
		vc_state_next = vc_state_reg;
		unique case (vc_state_reg)
			PPS_VC_IDLE: begin
				if (attached_reg && dfp && ctrl_reg[CTRL_VCONN_AUTO] && ra_pin) begin
					vc_state_next = PPS_VC_ON;
				end
			end
			PPS_VC_ON: begin
				if (vc_fault) begin
					vc_state_next = PPS_VC_LOCKED;
				end else if (!attached_reg || !dfp || !ctrl_reg[CTRL_VCONN_AUTO]) begin
					vc_state_next = PPS_VC_IDLE;
				end
			end
			PPS_VC_LOCKED: begin
				if (!attached_reg) begin
					vc_state_next = PPS_VC_IDLE;
				end
			end
			default: begin
				vc_state_next = PPS_VC_IDLE;
			end
		endcase
	end

	assign vc_oc = (vc_state_reg == PPS_VC_ON) && vc_fault;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vc_state_reg <= PPS_VC_IDLE;
		end else begin
			vc_state_reg <= vc_state_next;
		end
	end

	// Both enables derive from one state and the opposite polarity of one bit.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port1_cable_supply_enable_a <= 1'b0;
			port1_cable_supply_enable_b <= 1'b0;
		end else begin
			port1_cable_supply_enable_a <= (vc_state_next == PPS_VC_ON) && orient_reg;
			port1_cable_supply_enable_b <= (vc_state_next == PPS_VC_ON) && !orient_reg;
		end
	end

	assign stat_set = {vbus_win && !vbus_win_prev_reg,
		!attached_next && attached_reg,
		attached_next && !attached_reg,
		vc_oc,
		ss_oc & ~ss_oc_prev_reg,
		main_oc & ~main_oc_prev_reg};

	// A new event in the clearing cycle survives the write of one.
	always_comb begin
		stat_next = stat_reg;
		if (wr_stat) begin
			stat_next = stat_reg & ~bus_wdata[ST_W-1:0];
		end
		stat_next = stat_next | stat_set;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= stat_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end

	// Read data stand only in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_rdata <= '0;
		end else if (!bus_rd) begin
			bus_rdata <= '0;
		end else begin
			unique case (bus_addr)
				REG_CTRL: bus_rdata <= {13'h0000, ctrl_reg};
				REG_SPLIT: bus_rdata <= {8'h00, split_eff, split_reg};
				REG_PWR: bus_rdata <= {8'h00, pwr_reg};
				REG_STAT: bus_rdata <= {4'h0, stat_reg};
				REG_MASK: bus_rdata <= {4'h0, mask_reg};
				REG_STATE: bus_rdata <= {7'h00, cfg_reg, vc_state_reg == PPS_VC_LOCKED,
					pd_ok_reg, vbus_win, port1_cable_supply_enable_b,
					port1_cable_supply_enable_a, orient_reg, attached_reg, dfp};
				REG_OCLIVE: bus_rdata <= {7'h00, vc_fault, ss_oc, main_oc};
				default: bus_rdata <= '0;
			endcase
		end
	end
endmodule : pps_port_power

// ---- hdl/pps_sync.sv ----
module pps_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : pps_sync

// ---- verification/pps_far_side_model.sv ----
module pps_far_side_model
	import pps_pkg::*;
(
	input wire logic clk,
	input wire logic [NPORT-1:0] main_oe_b,
	input wire logic [NPORT-1:0] main_pu,
	input wire logic [NPORT-1:0] ss_oe_b,
	input wire logic [NPORT-1:0] ss_pu,
	input wire logic [NPORT-1:0] oc_main,
	input wire logic [NPORT-1:0] oc_ss,
	output logic [NPORT-1:0] main_in,
	output logic [NPORT-1:0] ss_in,
	input wire logic attach,
	input wire logic flip,
	input wire logic short,
	input wire logic en_a,
	input wire logic en_b,
	output logic cc1_term,
	output logic cc2_term,
	output logic cc1_ra,
	output logic cc2_ra,
	output logic cc1_low,
	output logic cc2_low
);
	// A released pin without pull-up floats, so it toggles rather than holding a level.
	logic float_bit = 1'b0;
	always_ff @(posedge clk) begin
		float_bit <= !float_bit;
	end
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			main_in[i] = !main_oe_b[i] ? 1'b0 : (main_pu[i] ? !oc_main[i] : float_bit);
			ss_in[i] = !ss_oe_b[i] ? 1'b0 : (ss_pu[i] ? !oc_ss[i] : float_bit);
		end
	end
	// The plug's Ra sits on the pin opposite the signalling one.
	assign cc1_term = attach && !flip;
	assign cc2_term = attach && flip;
	assign cc1_ra = attach && flip;
	assign cc2_ra = attach && !flip;
	// An unsupplied pin is below the threshold as well.
	assign cc1_low = !en_a || short;
	assign cc2_low = !en_b || short;
endmodule : pps_far_side_model

// ---- verification/pps_port_power_checker.sv ----
module pps_port_power_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cc1_term_det,
	input wire logic cc2_term_det,
	input wire logic cc1_ra_det,
	input wire logic cc2_ra_det,
	input wire logic cc1_vconn_low,
	input wire logic cc2_vconn_low,
	input wire logic [pps_pkg::NPORT-1:0] port_power_sense_pin_out,
	input wire logic [pps_pkg::NPORT-1:0] port_power_sense_pin_oe_b,
	input wire logic [pps_pkg::NPORT-1:0] port_power_sense_pin_pu_en,
	input wire logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_out,
	input wire logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_oe_b,
	input wire logic [pps_pkg::NPORT-1:0] superspeed_power_sense_pin_pu_en,
	input wire logic port1_cable_supply_enable_a,
	input wire logic port1_cable_supply_enable_b
);
	import pps_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [9:0] short_cnt;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			short_cnt <= 10'h000;
		end else if ((port1_cable_supply_enable_a && cc1_vconn_low)
			|| (port1_cable_supply_enable_b && cc2_vconn_low)) begin
			short_cnt <= short_cnt + 10'h001;
		end else begin
			short_cnt <= 10'h000;
		end
	end
	sequence s_detached;
		!(cc1_term_det || cc2_term_det) [*8];
	endsequence
	a_supply_one_pin: assert property (!(port1_cable_supply_enable_a
		&& port1_cable_supply_enable_b))
		else $error("both cable supply enables high");
	a_main_pin_mode: assert property (port_power_sense_pin_oe_b == port_power_sense_pin_pu_en
		&& port_power_sense_pin_out == 4'h0)
		else $error("main pin drive and pull-up disagree");
	a_ss_pin_mode: assert property ((~superspeed_power_sense_pin_oe_b
		& superspeed_power_sense_pin_pu_en) == 4'h0 && superspeed_power_sense_pin_out == 4'h0)
		else $error("superspeed pin pulled up while driven");
	a_port1_no_split: assert property (superspeed_power_sense_pin_oe_b[0]
		&& !superspeed_power_sense_pin_pu_en[0])
		else $error("port 1 superspeed pin in use");
	a_fault_shutoff: assert property (short_cnt < 10'h200)
		else $error("cable supply kept on below threshold");
	a_supply_a_ra: assert property ($rose(port1_cable_supply_enable_a)
		|-> cc1_ra_det && $past(cc1_ra_det, 2))
		else $error("supply a raised without Ra on its pin");
	a_supply_b_ra: assert property ($rose(port1_cable_supply_enable_b)
		|-> cc2_ra_det && $past(cc2_ra_det, 2))
		else $error("supply b raised without Ra on its pin");
	a_detach_off: assert property (s_detached
		|-> !port1_cable_supply_enable_a && !port1_cable_supply_enable_b)
		else $error("cable supply on after detach");
endmodule : pps_port_power_checker

bind pps_port_power pps_port_power_checker pps_port_power_checker_i (.clk, .rst_b,
	.cc1_term_det, .cc2_term_det, .cc1_ra_det, .cc2_ra_det, .cc1_vconn_low, .cc2_vconn_low,
	.port_power_sense_pin_out, .port_power_sense_pin_oe_b, .port_power_sense_pin_pu_en,
	.superspeed_power_sense_pin_out, .superspeed_power_sense_pin_oe_b,
	.superspeed_power_sense_pin_pu_en, .port1_cable_supply_enable_a,
	.port1_cable_supply_enable_b);

// ---- verification/test_pps_port_power.sv ----
module test_pps_port_power;
	timeunit 1ns;
	timeprecision 1ps;
	import pps_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [15:0] bus_wdata = 16'h0000;
	logic bus_wr = 1'b0, bus_rd = 1'b0, pin_cfg_strap = 1'b0;
	logic safe5v = 1'b0, safe0v = 1'b0, attach = 1'b0, flip = 1'b0, short = 1'b0;
	logic [3:0] oc_main = 4'h0, oc_ss = 4'h0;
	logic [15:0] bus_rdata;
	logic irq, en_a, en_b, c1t, c2t, c1r, c2r, c1l, c2l;
	logic [3:0] m_in, m_out, m_oe, m_pu, s_in, s_out, s_oe, s_pu;
	int mismatches = 0;
	int checks_done = 0;
	always #2 clk = !clk;
	pps_port_power pps_port_power_i (.clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
		.bus_rdata, .irq, .pin_cfg_strap, .cc1_term_det(c1t), .cc2_term_det(c2t),
		.cc1_ra_det(c1r), .cc2_ra_det(c2r), .cc1_vconn_low(c1l), .cc2_vconn_low(c2l),
		.bus_voltage_monitor_in_safe5v(safe5v), .bus_voltage_monitor_in_safe0v(safe0v),
		.port_power_sense_pin_in(m_in), .port_power_sense_pin_out(m_out),
		.port_power_sense_pin_oe_b(m_oe), .port_power_sense_pin_pu_en(m_pu),
		.superspeed_power_sense_pin_in(s_in), .superspeed_power_sense_pin_out(s_out),
		.superspeed_power_sense_pin_oe_b(s_oe), .superspeed_power_sense_pin_pu_en(s_pu),
		.port1_cable_supply_enable_a(en_a), .port1_cable_supply_enable_b(en_b));
	pps_far_side_model pps_far_side_model_i (.clk, .main_oe_b(m_oe), .main_pu(m_pu),
		.ss_oe_b(s_oe), .ss_pu(s_pu), .oc_main, .oc_ss, .main_in(m_in), .ss_in(s_in),
		.attach, .flip, .short, .en_a, .en_b, .cc1_term(c1t), .cc2_term(c2t), .cc1_ra(c1r),
		.cc2_ra(c2r), .cc1_low(c1l), .cc2_low(c2l));
	task automatic conclude;
		$display("Checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic chk(input string n, input logic [7:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		cmp(n, e, bus_rdata & m);
		// Return on a rising edge so that stimulus after a read changes on that edge.
		@(posedge clk);
	endtask : chk
	task automatic do_reset(input logic cfg2);
		rst_b <= 1'b0;
		pin_cfg_strap <= cfg2;
		idle(3);
		rst_b <= 1'b1;
		idle(5);
	endtask : do_reset
	initial begin
		#40us;
		mismatches++;
		conclude();
	end
	initial begin
		do_reset(1'b0);
		cmp("main_oe_b", 16'h0000, {12'h000, m_oe});
		chk("ctrl", REG_CTRL, 16'hFFFF, 16'h0002);
		chk("split", REG_SPLIT, 16'hFFFF, 16'h0000);
		chk("unmapped", 8'h1C, 16'hFFFF, 16'h0000);
		wr(REG_SPLIT, 16'h000F);
		wr(REG_PWR, 16'h0067);
		chk("split_cfg1", REG_SPLIT, 16'h00FF, 16'h00EF);
		cmp("main_oe", 16'h0007, {12'h000, m_oe});
		cmp("ss_oe", 16'h0007, {12'h000, s_oe});
		cmp("pull_up", 16'h0067, {8'h00, s_pu, m_pu});
		cmp("pin_out", 16'h0000, {8'h00, s_out, m_out});
		wr(REG_PWR, 16'h00FF);
		wr(REG_MASK, 16'h0FFF);
		wr(REG_STAT, 16'hFFFF);
		oc_main[0] <= 1'b1;
		idle(200);
		oc_main[0] <= 1'b0;
		chk("oc_glitch", REG_STAT, 16'h00FF, 16'h0000);
		oc_main[0] <= 1'b1;
		oc_ss <= 4'h9;
		idle(300);
		chk("oc_flags", REG_STAT, 16'h00FF, 16'h0081);
		chk("oc_live", REG_OCLIVE, 16'h01FF, 16'h0081);
		cmp("irq_set", 16'h0001, {15'h0000, irq});
		oc_main[0] <= 1'b0;
		oc_ss <= 4'h0;
		wr(REG_MASK, 16'h0000);
		idle(2);
		cmp("irq_masked", 16'h0000, {15'h0000, irq});
		wr(REG_MASK, 16'h0FFF);
		wr(REG_STAT, 16'h0081);
		chk("oc_clear", REG_STAT, 16'h00FF, 16'h0000);
		do_reset(1'b1);
		wr(REG_SPLIT, 16'h000F);
		chk("split_cfg2", REG_SPLIT, 16'h00FF, 16'h008F);
		chk("strap", REG_STATE, 16'h0180, 16'h0100);
		wr(REG_CTRL, 16'h0003);
		wr(REG_STAT, 16'hFFFF);
		for (int o = 0; o < 2; o++) begin
			flip <= o[0];
			attach <= 1'b1;
			idle(12);
			cmp("supply_on", o[0] ? 16'h0002 : 16'h0001, {14'h0000, en_a, en_b});
			short <= 1'b1;
			idle(520);
			cmp("supply_fault", 16'h0000, {14'h0000, en_a, en_b});
			short <= 1'b0;
			idle(20);
			cmp("supply_locked", 16'h0000, {14'h0000, en_a, en_b});
			chk("cable_lock", REG_STATE, 16'h0080, 16'h0080);
			chk("cable_oc", REG_STAT, 16'h0700, 16'h0300);
			attach <= 1'b0;
			idle(12);
			wr(REG_STAT, 16'hFFFF);
		end
		wr(REG_CTRL, 16'h0000);
		wr(REG_STAT, 16'hFFFF);
		safe5v <= 1'b1;
		idle(8);
		chk("ufp_attach", REG_STAT, 16'h0600, 16'h0200);
		safe5v <= 1'b0;
		safe0v <= 1'b1;
		idle(8);
		chk("ufp_detach", REG_STAT, 16'h0600, 16'h0600);
		chk("win_5v", REG_STATE, 16'h0020, 16'h0000);
		wr(REG_CTRL, 16'h0004);
		chk("win_0v", REG_STATE, 16'h0020, 16'h0020);
		safe0v <= 1'b0;
		safe5v <= 1'b1;
		attach <= 1'b1;
		wr(REG_CTRL, 16'h0003);
		idle(12);
		chk("pd_ok", REG_STATE, 16'h0060, 16'h0060);
		conclude();
	end
endmodule : test_pps_port_power
